// file: core/ssr_edge_detect.sv
// Transition detector for one status group.
// Assumes the condition vector is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none

module ssr_edge_detect #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_b_in,
    // Condition and filters
    input  wire logic [W-1:0] cond_in,
    input  wire logic [W-1:0] rise_sel_in,
    input  wire logic [W-1:0] fall_sel_in,
    // Event bits to set
    output logic      [W-1:0] set_out
);

    logic [W-1:0] prev_q;
    logic         armed_q;

    // Previous condition, armed after first sample
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_q  <= '0;
            armed_q <= 1'b0;
        end else begin
            prev_q  <= cond_in;
            armed_q <= 1'b1;
        end
    end

    // Rising and falling edges through filters
    assign set_out = armed_q ? ((cond_in & ~prev_q & rise_sel_in)
                             | (~cond_in & prev_q & fall_sel_in))
                             : '0;

endmodule

`default_nettype wire

// file: core/ssr_err_fifo.sv
// First-in first-out error queue holding a code and a text identifier.
// Assumes push when full is dropped; clear with push keeps the new entry.
`timescale 1ns/10ps
`default_nettype none

module ssr_err_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 30
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_b_in,
    // Fill and drain
    input  wire logic         push_in,
    input  wire logic [W-1:0] push_data_in,
    input  wire logic         pop_in,
    input  wire logic         clear_in,
    // Head and state
    output logic      [W-1:0] head_out,
    output logic              empty_out,
    output logic              full_out,
    output logic      [7:0]   count_out
);

    logic [W-1:0] mem [DEPTH];
    logic [7:0]   wr_q;
    logic [7:0]   rd_q;
    logic [7:0]   cnt_q;
    wire          do_push = push_in && !full_out;
    wire          do_pop  = pop_in && !empty_out && !clear_in;

    // Wrapping pointer step
    function automatic logic [7:0] step(input logic [7:0] p);
        step = (p == 8'(DEPTH - 1)) ? 8'h00 : p + 8'h01;
    endfunction

    assign empty_out = (cnt_q == 8'h00);
    assign full_out  = (cnt_q == 8'(DEPTH)) && !clear_in;
    assign head_out  = mem[rd_q[4:0]];
    assign count_out = cnt_q;

    // Entry storage
    always_ff @(posedge mclk_in) begin
        if (do_push) begin
            mem[clear_in ? 5'h00 : wr_q[4:0]] <= push_data_in;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_q  <= 8'h00;
            rd_q  <= 8'h00;
            cnt_q <= 8'h00;
        end else if (clear_in) begin
            wr_q  <= do_push ? 8'h01 : 8'h00;
            rd_q  <= 8'h00;
            cnt_q <= do_push ? 8'h01 : 8'h00;
        end else begin
            wr_q  <= do_push ? step(wr_q) : wr_q;
            rd_q  <= do_pop ? step(rd_q) : rd_q;
            cnt_q <= cnt_q + (do_push ? 8'h01 : 8'h00) - (do_pop ? 8'h01 : 8'h00);
        end
    end

endmodule

`default_nettype wire

// file: core/ssr_status_core.sv
// Status reporting core: operation and questionable groups, status byte
// summary bits and the error queue; groups and queue are set up and read by host commands.
// Assumes commands and condition inputs are synchronous to mclk_in and
// that the host issues at most one command per cycle.
`timescale 1ns/10ps
`default_nettype none

module ssr_status_core #(
    parameter int ERR_DEPTH = ssr_pkg::ERR_DEPTH,
    parameter int TEXT_W    = ssr_pkg::TEXT_W
) (
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_b_in,
    // Monitored conditions
    input  wire logic [15:0]       oper_cond_in,
    input  wire logic [15:0]       ques_cond_in,
    // Error reports from the instrument
    input  wire logic              err_push_in,
    input  wire logic [15:0]       err_code_in,
    input  wire logic [TEXT_W-1:0] err_text_in,
    // Host command
    input  wire logic              cmd_valid_in,
    input  wire logic [3:0]        cmd_op_in,
    input  wire logic              cmd_grp_in,
    input  wire logic [15:0]       cmd_data_in,
    // Host response
    output logic                   rsp_valid_out,
    output logic      [15:0]       rsp_value_out,
    output logic      [TEXT_W-1:0] rsp_text_out,
    // Status byte and queue state
    output logic      [7:0]        status_byte_out,
    output logic      [7:0]        err_count_out
);

    // ****************************************************
    // Command decode
    // ****************************************************

    // True when the command targets the given group
    function automatic logic grp_hit(input logic v, input logic [3:0] op,
                                     input ssr_pkg::ssr_cmd_t want,
                                     input logic g, input logic target);
        grp_hit = v && (op == want) && (g == target);
    endfunction

    // True for commands that answer the host
    function automatic logic is_query(input logic [3:0] op);
        is_query = (op == ssr_pkg::SSR_CMD_COND_RD) || (op == ssr_pkg::SSR_CMD_EN_RD)
                || (op == ssr_pkg::SSR_CMD_EVT_RD)  || (op == ssr_pkg::SSR_CMD_FALL_RD)
                || (op == ssr_pkg::SSR_CMD_RISE_RD) || (op == ssr_pkg::SSR_CMD_ERR_RD);
    endfunction

    // Group-independent commands
    wire preset_w = cmd_valid_in && (cmd_op_in == ssr_pkg::SSR_CMD_PRESET);
    wire cls_w    = cmd_valid_in && (cmd_op_in == ssr_pkg::SSR_CMD_CLS);
    wire err_rd_w = cmd_valid_in && (cmd_op_in == ssr_pkg::SSR_CMD_ERR_RD);
    wire query_w  = cmd_valid_in && is_query(cmd_op_in);

    // ****************************************************
    // Per-group storage and event logic
    // ****************************************************

    logic [15:0] cond_w  [2];
    logic [15:0] en_q    [2];
    logic [15:0] rise_q  [2];
    logic [15:0] fall_q  [2];
    logic [15:0] ev_q    [2];
    logic [15:0] set_w   [2];
    logic        sum_w   [2];

    // Top bit of each condition can never be true
    assign cond_w[0] = oper_cond_in & ssr_pkg::COND_MASK;
    assign cond_w[1] = ques_cond_in & ssr_pkg::COND_MASK;

    for (genvar g = 0; g < 2; g++) begin : gen_grp
        localparam logic GID = 1'(g);

        wire en_wr   = grp_hit(cmd_valid_in, cmd_op_in, ssr_pkg::SSR_CMD_EN_WR,
                               cmd_grp_in, GID);
        wire rise_wr = grp_hit(cmd_valid_in, cmd_op_in, ssr_pkg::SSR_CMD_RISE_WR,
                               cmd_grp_in, GID);
        wire fall_wr = grp_hit(cmd_valid_in, cmd_op_in, ssr_pkg::SSR_CMD_FALL_WR,
                               cmd_grp_in, GID);
        wire ev_rd   = grp_hit(cmd_valid_in, cmd_op_in, ssr_pkg::SSR_CMD_EVT_RD,
                               cmd_grp_in, GID);
        wire ev_clr  = ev_rd || cls_w;

        // Edge detection through the two filters
        ssr_edge_detect #(
            .W (ssr_pkg::GRP_W)
        ) u_edge (
            .mclk_in     (mclk_in),
            .rst_b_in    (rst_b_in),
            .cond_in     (cond_w[g]),
            .rise_sel_in (rise_q[g]),
            .fall_sel_in (fall_q[g]),
            .set_out     (set_w[g])
        );

        // Enable mask: full width stored, preset to zero
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                en_q[g] <= ssr_pkg::PRESET_EN;
            end else if (preset_w) begin
                en_q[g] <= ssr_pkg::PRESET_EN;
            end else if (en_wr) begin
                en_q[g] <= cmd_data_in;
            end
        end

        // Transition filters: top bit never stored
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                rise_q[g] <= ssr_pkg::PRESET_RISE;
                fall_q[g] <= ssr_pkg::PRESET_FALL;
            end else if (preset_w) begin
                rise_q[g] <= ssr_pkg::PRESET_RISE;
                fall_q[g] <= ssr_pkg::PRESET_FALL;
            end else begin
                if (rise_wr) begin
                    rise_q[g] <= cmd_data_in & ssr_pkg::FILT_MASK;
                end
                if (fall_wr) begin
                    fall_q[g] <= cmd_data_in & ssr_pkg::FILT_MASK;
                end
            end
        end

        // Event latch: new edges win over a same-cycle clear
        always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                ev_q[g] <= 16'h0000;
            end else begin
                ev_q[g] <= (ev_clr ? 16'h0000 : ev_q[g]) | set_w[g];
            end
        end

        // Summary: any enabled latched event
        assign sum_w[g] = |(ev_q[g] & en_q[g]);
    end

    // ****************************************************
    // Error queue
    // ****************************************************

    logic [15+TEXT_W:0] err_head_w;
    logic               err_empty_w;

    // Queue pops on each read, empties on clear-status
    ssr_err_fifo #(
        .W     (16 + TEXT_W),
        .DEPTH (ERR_DEPTH)
    ) u_err (
        .mclk_in      (mclk_in),
        .rst_b_in     (rst_b_in),
        .push_in      (err_push_in),
        .push_data_in ({err_code_in, err_text_in}),
        .pop_in       (err_rd_w),
        .clear_in     (cls_w),
        .head_out     (err_head_w),
        .empty_out    (err_empty_w),
        .full_out     (),
        .count_out    (err_count_out)
    );

    // Error answer: empty queue gives the no-errors entry
    wire [15:0]       err_code_w = err_empty_w ? ssr_pkg::NO_ERR_CODE
                                               : err_head_w[15+TEXT_W:TEXT_W];
    wire [TEXT_W-1:0] err_text_w = err_empty_w ? TEXT_W'(ssr_pkg::NO_ERR_TEXT)
                                               : err_head_w[TEXT_W-1:0];

    // ****************************************************
    // Response selection
    // ****************************************************

    wire       gsel = cmd_grp_in;
    logic [15:0] sel_value_w;

    // Pick the value the current query returns; reads of
    // conditions and filters have no side effect
    always_comb begin
        sel_value_w = 16'h0000;
        case (cmd_op_in)
            ssr_pkg::SSR_CMD_COND_RD: sel_value_w = cond_w[gsel];
            ssr_pkg::SSR_CMD_EN_RD:   sel_value_w = en_q[gsel];
            ssr_pkg::SSR_CMD_EVT_RD:  sel_value_w = ev_q[gsel];
            ssr_pkg::SSR_CMD_FALL_RD: sel_value_w = fall_q[gsel];
            ssr_pkg::SSR_CMD_RISE_RD: sel_value_w = rise_q[gsel];
            ssr_pkg::SSR_CMD_ERR_RD:  sel_value_w = err_code_w;
            default:                  sel_value_w = 16'h0000;
        endcase
    end

    wire [TEXT_W-1:0] sel_text_w = err_rd_w ? err_text_w : '0;

    // ****************************************************
    // Registered outputs
    // ****************************************************

    logic              rsp_valid_q;
    logic [15:0]       rsp_value_q;
    logic [TEXT_W-1:0] rsp_text_q;
    logic [7:0]        status_byte_q;

    // Answer one cycle after the query
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rsp_valid_q <= 1'b0;
            rsp_value_q <= 16'h0000;
            rsp_text_q  <= '0;
        end else begin
            rsp_valid_q <= query_w;
            if (query_w) begin
                rsp_value_q <= sel_value_w;
                rsp_text_q  <= sel_text_w;
            end
        end
    end

    // Status byte carries the two summary bits
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_byte_q <= 8'h00;
        end else begin
            status_byte_q                       <= 8'h00;
            status_byte_q[ssr_pkg::SB_QUES_BIT] <= sum_w[ssr_pkg::GRP_QUES];
            status_byte_q[ssr_pkg::SB_OPER_BIT] <= sum_w[ssr_pkg::GRP_OPER];
        end
    end

    assign rsp_valid_out   = rsp_valid_q;
    assign rsp_value_out   = rsp_value_q;
    assign rsp_text_out    = rsp_text_q;
    assign status_byte_out = status_byte_q;

endmodule

`default_nettype wire

// file: pkg/ssr_pkg.sv
// Constants, command codes and reset values for the status reporting block.
// Assumes one clock domain and a host that issues one command per cycle at most.
//
// Notes on behaviour
// - Each group offers a live condition value from 0 to 32767 that tracks its inputs.
// - Each group's 16-bit enable mask is written by the host and read back unchanged.
// - An event bit set together with its mask bit sets status byte bit 3 or bit 7.
// - Reading an event register returns its latched bits and then clears all but those with a new edge that cycle.
// - A condition bit going from 1 to 0 sets its event bit when the fall filter selects it.
// - A condition bit going from 0 to 1 sets its event bit when the rise filter selects it.
// - Filters accept 0 to 65535 but drop the top bit, so they read back at most 32767.
// - Status preset puts masks to 0, rise filters to 32767 and fall filters to 0.
// - Status preset leaves events and the queue alone; clear-status empties both but keeps same-cycle edges and pushes.
// - Errors sit in a 30-entry first-in first-out queue and are read in arrival order.
// - An error read on an empty queue returns code +0 with the no-errors text.
// - Each error read returns a signed code together with its text identifier.

package ssr_pkg;

    // ****************************************************
    // Widths and group selection
    // ****************************************************
    localparam int          GRP_W       = 16;
    localparam int          TEXT_W      = 8;
    localparam int          ERR_DEPTH   = 30;
    localparam logic        GRP_OPER    = 1'b0;
    localparam logic        GRP_QUES    = 1'b1;

    // ****************************************************
    // Field masks and status byte positions
    // ****************************************************
    localparam logic [15:0] COND_MASK   = 16'h7fff;
    localparam logic [15:0] FILT_MASK   = 16'h7fff;
    localparam int          SB_QUES_BIT = 3;
    localparam int          SB_OPER_BIT = 7;

    // ****************************************************
    // Preset, reset and empty-queue answer values
    // ****************************************************
    localparam logic [15:0] PRESET_EN   = 16'h0000;
    localparam logic [15:0] PRESET_RISE = 16'h7fff;
    localparam logic [15:0] PRESET_FALL = 16'h0000;
    localparam logic [15:0] NO_ERR_CODE = 16'h0000;
    localparam logic [7:0]  NO_ERR_TEXT = 8'h00;

    // ****************************************************
    // Host command codes
    // ****************************************************
    typedef enum logic [3:0] {
        SSR_CMD_COND_RD  = 4'h0,
        SSR_CMD_EN_WR    = 4'h1,
        SSR_CMD_EN_RD    = 4'h2,
        SSR_CMD_EVT_RD   = 4'h3,
        SSR_CMD_FALL_WR  = 4'h4,
        SSR_CMD_FALL_RD  = 4'h5,
        SSR_CMD_RISE_WR  = 4'h6,
        SSR_CMD_RISE_RD  = 4'h7,
        SSR_CMD_PRESET   = 4'h8,
        SSR_CMD_CLS      = 4'h9,
        SSR_CMD_ERR_RD   = 4'ha
    } ssr_cmd_t;

endpackage

// file: testbench/ssr_host_model.sv
// Host controller model issuing status commands.
// Assumes the core answers queries exactly one cycle after taking them.
`timescale 1ns/10ps
`default_nettype none

module ssr_host_model (
    // Clock
    input  wire logic        mclk_in,
    // Command lines
    output logic             cmd_valid_out,
    output logic [3:0]       cmd_op_out,
    output logic             cmd_grp_out,
    output logic [15:0]      cmd_data_out,
    // Answer lines
    input  wire logic        rsp_valid_in,
    input  wire logic [15:0] rsp_value_in,
    input  wire logic [7:0]  rsp_text_in
);
    // Idle lines at time zero
    initial begin
        cmd_valid_out = 1'b0;
        cmd_op_out    = 4'hf;
        cmd_grp_out   = 1'b0;
        cmd_data_out  = 16'h0000;
    end

    // One command pulse; released lines show inverted values
    task automatic send(input logic [3:0] op, input logic g, input logic [15:0] d);
        @(posedge mclk_in);
        cmd_valid_out <= 1'b1;
        cmd_op_out    <= op;
        cmd_grp_out   <= g;
        cmd_data_out  <= d;
        @(posedge mclk_in);
        cmd_valid_out <= 1'b0;
        cmd_op_out    <= ~op;
        cmd_grp_out   <= ~g;
        cmd_data_out  <= ~d;
    endtask

    // Query, then take the answer in the cycle after
    task automatic ask(input logic [3:0] op, input logic g, output logic v,
                       output logic [15:0] val, output logic [7:0] txt);
        send(op, g, 16'h0000);
        #1;
        v   = rsp_valid_in;
        val = rsp_value_in;
        txt = rsp_text_in;
    endtask
endmodule
`default_nettype wire

// file: testbench/ssr_status_core_assertions.sv
// Port checker for the status reporting core.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/10ps
`default_nettype none

module ssr_status_core_assertions #(
    parameter int ERR_DEPTH = 30,
    parameter int TEXT_W    = 8
) (
    // Clock and reset
    input wire logic              mclk_in,
    input wire logic              rst_b_in,
    // Inputs
    input wire logic [15:0]       oper_cond_in,
    input wire logic              err_push_in,
    input wire logic              cmd_valid_in,
    input wire logic [3:0]        cmd_op_in,
    input wire logic              cmd_grp_in,
    // Outputs
    input wire logic              rsp_valid_out,
    input wire logic [15:0]       rsp_value_out,
    input wire logic [TEXT_W-1:0] rsp_text_out,
    input wire logic [7:0]        status_byte_out,
    input wire logic [7:0]        err_count_out
);
    // ********************************
    // Command decoding
    // ********************************
    wire logic [3:0] op      = cmd_op_in;
    wire logic       err_rd  = cmd_valid_in && op == ssr_pkg::SSR_CMD_ERR_RD;
    wire logic       cls     = cmd_valid_in && op == ssr_pkg::SSR_CMD_CLS;
    wire logic       preset  = cmd_valid_in && op == ssr_pkg::SSR_CMD_PRESET;
    wire logic       cond_rd = cmd_valid_in && !cmd_grp_in && op == ssr_pkg::SSR_CMD_COND_RD;
    wire logic       filt_rd = cmd_valid_in && (op == ssr_pkg::SSR_CMD_FALL_RD
                               || op == ssr_pkg::SSR_CMD_RISE_RD);
    wire logic       qry     = filt_rd || cond_rd || err_rd || (cmd_valid_in
                               && op inside {ssr_pkg::SSR_CMD_COND_RD,
                               ssr_pkg::SSR_CMD_EN_RD, ssr_pkg::SSR_CMD_EVT_RD});

    // ********************************
    // Properties
    // ********************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_rsp_due: assert property (qry |=> rsp_valid_out)
        else $error("query not answered next cycle");
    a_rsp_cause: assert property (rsp_valid_out |-> $past(qry))
        else $error("answer without a query");
    a_cond_live: assert property (cond_rd && $stable(oper_cond_in)
        |=> rsp_value_out == ($past(oper_cond_in) & ssr_pkg::COND_MASK))
        else $error("condition read wrong");
    a_filt_top: assert property (filt_rd |=> !rsp_value_out[15])
        else $error("filter top bit read back");
    a_sum_preset: assert property (preset ##1 !cmd_valid_in |=> status_byte_out == 8'h00)
        else $error("summary set after preset");
    a_sb_spare: assert property ((status_byte_out & 8'h77) == 8'h00)
        else $error("spare status byte bit set");
    a_empty_zero: assert property (err_rd && err_count_out == 8'h00 && !err_push_in
        |=> rsp_value_out == 16'h0000 && rsp_text_out == '0)
        else $error("empty queue read not zero");
    a_pop_count: assert property (err_rd && err_count_out != 8'h00 && !err_push_in
        |=> err_count_out == $past(err_count_out) - 8'h01)
        else $error("queue read did not pop");
    a_push_count: assert property (err_push_in && !cmd_valid_in && err_count_out < ERR_DEPTH
        |=> err_count_out == $past(err_count_out) + 8'h01)
        else $error("queue push not counted");
    a_full_keep: assert property (err_push_in && err_count_out == ERR_DEPTH && !cmd_valid_in
        |=> $stable(err_count_out))
        else $error("full queue grew");
    a_cls_empty: assert property (cls && !err_push_in |=> err_count_out == 8'h00)
        else $error("clear left queue entries");
    a_preset_keep: assert property (preset && !err_push_in |=> $stable(err_count_out))
        else $error("preset changed queue");

    // Main scenarios reached
    c_oper_sum: cover property (status_byte_out[7]);
    c_ques_sum: cover property (status_byte_out[3]);
    c_queue_full: cover property (err_push_in && err_count_out == ERR_DEPTH);
endmodule

bind ssr_status_core ssr_status_core_assertions #(
    .ERR_DEPTH(ERR_DEPTH),
    .TEXT_W   (TEXT_W)
) chk_i (
    .mclk_in        (mclk_in),
    .rst_b_in       (rst_b_in),
    .oper_cond_in   (oper_cond_in),
    .err_push_in    (err_push_in),
    .cmd_valid_in   (cmd_valid_in),
    .cmd_op_in      (cmd_op_in),
    .cmd_grp_in     (cmd_grp_in),
    .rsp_valid_out  (rsp_valid_out),
    .rsp_value_out  (rsp_value_out),
    .rsp_text_out   (rsp_text_out),
    .status_byte_out(status_byte_out),
    .err_count_out  (err_count_out)
);
`default_nettype wire

// file: testbench/ssr_status_core_test.sv
// Self-checking bench for the status reporting core.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module ssr_status_core_test;
    // ********************************
    // Signals and bookkeeping
    // ********************************
    logic        mclk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [15:0] oper_cond_in = 16'h0000;
    logic [15:0] ques_cond_in = 16'h0000;
    logic        err_push_in = 1'b0;
    logic [15:0] err_code_in = 16'h0000;
    logic [7:0]  err_text_in = 8'h00;
    wire logic   cmd_valid_in, cmd_grp_in, rsp_valid_out;
    wire logic [3:0]  cmd_op_in;
    wire logic [15:0] cmd_data_in, rsp_value_out;
    wire logic [7:0]  rsp_text_out, status_byte_out, err_count_out;
    int          mismatches = 0;
    int          total_checks = 0;
    logic        v;
    logic [15:0] val, a, b, r, f, m, e;
    logic [7:0]  txt;
    logic [15:0] codes [31];
    logic [7:0]  texts [31];

    // Clock at 125 MHz
    always #4 mclk_in = ~mclk_in;

    ssr_status_core ssr_status_core_i (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in),
        .err_push_in(err_push_in), .err_code_in(err_code_in), .err_text_in(err_text_in),
        .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_grp_in(cmd_grp_in),
        .cmd_data_in(cmd_data_in), .rsp_valid_out(rsp_valid_out),
        .rsp_value_out(rsp_value_out), .rsp_text_out(rsp_text_out),
        .status_byte_out(status_byte_out), .err_count_out(err_count_out)
    );
    ssr_host_model ssr_host_model_i (
        .mclk_in(mclk_in), .cmd_valid_out(cmd_valid_in), .cmd_op_out(cmd_op_in),
        .cmd_grp_out(cmd_grp_in), .cmd_data_out(cmd_data_in), .rsp_valid_in(rsp_valid_out),
        .rsp_value_in(rsp_value_out), .rsp_text_in(rsp_text_out)
    );

    // ********************************
    // Compare, drive and verdict tasks
    // ********************************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] op, input logic g, input logic [15:0] exp);
        ssr_host_model_i.ask(op, g, v, val, txt);
        chk_byte({7'h00, v}, 8'h01);
        chk_val(val, exp);
    endtask
    task automatic set_cond(input logic g, input logic [15:0] c);
        @(posedge mclk_in);
        if (g)
            ques_cond_in <= c;
        else
            oper_cond_in <= c;
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic push(input logic [15:0] c, input logic [7:0] t);
        @(posedge mclk_in);
        err_push_in <= 1'b1;
        err_code_in <= c;
        err_text_in <= t;
        @(posedge mclk_in);
        err_push_in <= 1'b0;
        err_code_in <= ~c;
        err_text_in <= ~t;
        #1;
    endtask
    function automatic logic [15:0] exp_evt(input logic [15:0] a0, b0, r0, f0);
        return ((~a0 & b0 & r0) | (a0 & ~b0 & f0)) & 16'h7fff;
    endfunction
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h129da9b9));
        repeat (10) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            a = (k < 2) ? 16'hffff : 16'($urandom);
            if (k < 2) begin
                rd(ssr_pkg::SSR_CMD_EN_RD, k[0], 16'h0000);
                rd(ssr_pkg::SSR_CMD_RISE_RD, k[0], 16'h7fff);
                rd(ssr_pkg::SSR_CMD_FALL_RD, k[0], 16'h0000);
            end
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_EN_WR, k[0], a);
            rd(ssr_pkg::SSR_CMD_EN_RD, k[0], a);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_FALL_WR, k[0], a);
            rd(ssr_pkg::SSR_CMD_FALL_RD, k[0], a & 16'h7fff);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_RISE_WR, k[0], ~a);
            rd(ssr_pkg::SSR_CMD_RISE_RD, k[0], ~a & 16'h7fff);
        end
        for (int k = 0; k < 8; k++) begin
            a = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : 16'($urandom);
            b = (k < 2) ? ~a : 16'($urandom);
            r = (k < 2) ? 16'hffff : 16'($urandom);
            f = (k < 2) ? 16'hffff : 16'($urandom);
            m = (k < 2) ? 16'hffff : 16'($urandom);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_PRESET, k[0], 16'h0000);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_RISE_WR, k[0], r);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_FALL_WR, k[0], f);
            set_cond(k[0], a);
            ssr_host_model_i.ask(ssr_pkg::SSR_CMD_EVT_RD, k[0], v, val, txt);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_EN_WR, k[0], m);
            set_cond(k[0], b);
            e = exp_evt(a, b, r, f);
            chk_byte(status_byte_out, {|(e & m) & !k[0], 3'h0, |(e & m) & k[0], 3'h0});
            rd(ssr_pkg::SSR_CMD_COND_RD, k[0], b & 16'h7fff);
            rd(ssr_pkg::SSR_CMD_FALL_RD, k[0], f & 16'h7fff);
            ssr_host_model_i.send(ssr_pkg::SSR_CMD_PRESET, k[0], 16'h0000);
            rd(ssr_pkg::SSR_CMD_RISE_RD, k[0], 16'h7fff);
            rd(ssr_pkg::SSR_CMD_EN_RD, k[0], 16'h0000);
            chk_byte(status_byte_out, 8'h00);
            rd(ssr_pkg::SSR_CMD_EVT_RD, k[0], e);
            rd(ssr_pkg::SSR_CMD_EVT_RD, k[0], 16'h0000);
        end
        for (int i = 0; i < 31; i++) begin
            codes[i] = (i == 0) ? 16'h8000 : 16'($urandom);
            texts[i] = 8'($urandom);
            push(codes[i], texts[i]);
        end
        chk_byte(err_count_out, 8'h1e);
        for (int i = 0; i < 32; i++) begin
            ssr_host_model_i.ask(ssr_pkg::SSR_CMD_ERR_RD, 1'b0, v, val, txt);
            chk_val(val, (i < 30) ? codes[i] : 16'h0000);
            chk_byte(txt, (i < 30) ? texts[i] : 8'h00);
        end
        push(16'h0001, 8'h01);
        push(16'hff8f, 8'h02);
        set_cond(1'b0, 16'h0000);
        set_cond(1'b0, 16'h0001);
        ssr_host_model_i.send(ssr_pkg::SSR_CMD_PRESET, 1'b0, 16'h0000);
        #1;
        chk_byte(err_count_out, 8'h02);
        ssr_host_model_i.send(ssr_pkg::SSR_CMD_CLS, 1'b0, 16'h0000);
        #1;
        chk_byte(err_count_out, 8'h00);
        rd(ssr_pkg::SSR_CMD_EVT_RD, 1'b0, 16'h0000);
        rd(ssr_pkg::SSR_CMD_ERR_RD, 1'b0, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
